//--- design/hbsr_params.svh
// Constants for the host bus status and ROM paging block
`ifndef HBSR_PARAMS_SVH
`define HBSR_PARAMS_SVH

`define HBSR_MODE_ISA 2'h0
`define HBSR_MODE_UNBUFFERED_HOST_MODE 2'h1
`define HBSR_MODE_MC 2'h2
`define HBSR_PAGE_RST 3'h7
`define HBSR_SLOT_ID_LO 24'h000100
`define HBSR_SLOT_ID_HI 24'h000101
`define HBSR_ZWS_BIT 8
`define HBSR_CFG_W 9

`endif

//--- design/hbsr_pkg.sv
// Types shared by the host bus status and ROM paging block
package hbsr_pkg;
    typedef enum logic [1:0] {
        HBSR_ISA = 2'b00,
        HBSR_UNBUFFERED_HOST_MODE = 2'b01,
        HBSR_MC = 2'b10,
        HBSR_RSVD = 2'b11
    } hbsr_mode_e;

    typedef struct packed {
        logic mem_hit;
        logic io_hit;
        logic io16_hit;
        logic rom_hit;
        logic excl_hit;
        logic slot_io;
    } hbsr_dec_s;

    typedef struct packed {
        logic [2:0] sense;
        logic paging;
    } hbsr_strap_s;
endpackage

//--- design/hbsr_strap_latch.sv
// Captures straps on the release of reset
`timescale 1ns/1ps
`include "hbsr_params.svh"
module hbsr_strap_latch import hbsr_pkg::*; (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [2:0] sense_i,
    input wire logic paging_i,
    output hbsr_strap_s strap_o
);
    hbsr_strap_s strap_ff;

    // Pins are sampled while reset is held, when the external buffer still
    // drives them; the last sample before release is kept afterwards
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            strap_ff <= '{sense: sense_i, paging: paging_i};
        end
    end

    assign strap_o = strap_ff;
endmodule

//--- design/hbsr_decode.sv
// Address decode of host cycles
`timescale 1ns/1ps
`include "hbsr_params.svh"
module hbsr_decode import hbsr_pkg::*; #(
    parameter logic [23:0] MEM_BASE = 24'hA00000,
    parameter logic [23:0] MEM_MASK = 24'hFF0000,
    parameter logic [23:0] ROM_BASE = 24'h0C6000,
    parameter logic [23:0] ROM_MASK = 24'hFFE000,
    parameter logic [15:0] IO_MASK = 16'h03FF,
    parameter logic [15:0] IO_LOW = 16'h02E8
) (
    input wire logic [23:0] addr_i,
    input wire logic is_mem_i,
    input wire logic high_mem_i,
    input wire logic setup_i,
    output hbsr_dec_s dec_o
);
    function automatic logic hit(input logic [23:0] a, input logic [23:0] b,
                                 input logic [23:0] m);
        hit = ((a ^ b) & m) == 24'h000000;
    endfunction

    logic io_match;
    logic slot;

    always_comb begin
        io_match = (addr_i[15:0] & IO_MASK) == IO_LOW;
        slot = !is_mem_i && setup_i &&
               (addr_i == `HBSR_SLOT_ID_LO || addr_i == `HBSR_SLOT_ID_HI);
        dec_o.mem_hit = is_mem_i && high_mem_i && hit(addr_i, MEM_BASE, MEM_MASK);
        dec_o.rom_hit = is_mem_i && hit(addr_i, ROM_BASE, ROM_MASK);
        dec_o.io_hit = !is_mem_i && io_match;
        dec_o.io16_hit = !is_mem_i && io_match && !addr_i[0];
        dec_o.slot_io = slot;
        dec_o.excl_hit = slot || dec_o.rom_hit;
    end
endmodule

//--- design/hbsr_top.sv
// Host bus status, select and ROM page pin logic
//
// Behaviour
// - ISA mode leaves memory width acknowledge undriven
// - Unbuffered mode drives memory width acknowledge low on 16-bit memory hits
// - MC mode drives card select feedback low for any own access
// - ISA mode asserts io width acknowledge on 16-bit capable io hits
// - MC mode asserts transfer width acknowledge except palette, slot id, ROM
// - ISA interrupt pin floats when disabled, else shows pending level
// - MC interrupt pin is active-low open collector
// - Unbuffered with zero wait select turns interrupt pin into zero wait request
// - Zero wait request low on port writes not full or reads ready
// - ISA ROM select low for ROM space cycles
// - MC ROM select low for ROM space or setup slot id io
// - ROM select pin is an input during reset
// - ROM page pins latched at reset release as monitor sense code
// - Paging strap low keeps ROM page pins inputs
// - Paging strap high drives ROM page pins from page field
// - Setup mode forces all ROM page outputs high
// - Page field resets to seven
// - ISA io strobes ignored while address enable high
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "hbsr_params.svh"
module hbsr_top import hbsr_pkg::*; (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic [1:0] MODE_I,
    input wire logic [23:0] ADDR_I,
    input wire logic MEM_CYCLE_I,
    input wire logic HIGH_MEM_I,
    input wire logic IO_RD_N_I,
    input wire logic IO_WR_N_I,
    input wire logic MEM_RD_N_I,
    input wire logic MEM_WR_N_I,
    input wire logic ADDR_EN_I,
    input wire logic PALETTE_HIT_I,
    input wire logic SETUP_N_I,
    input wire logic PIXEL_PORT_HIT_I,
    input wire logic QUEUE_FULL_I,
    input wire logic READ_READY_I,
    input wire logic INT_ENABLE_I,
    input wire logic INT_PENDING_I,
    input wire logic [2:0] ROM_PAGE_PINS_I,
    input wire logic ROM_PAGING_STRAP_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [3:0] REG_ADDR_I,
    input wire logic [15:0] REG_WDATA_I,
    output logic [15:0] REG_RDATA_O,
    output logic MEM_WIDTH_ACK_N_O,
    output logic MEM_WIDTH_ACK_OE_O,
    output logic IO_WIDTH_ACK_N_O,
    output logic IO_WIDTH_ACK_OE_O,
    output logic INT_PIN_O,
    output logic INT_PIN_OE_O,
    output logic ROM_SELECT_N_O,
    output logic ROM_SELECT_OE_O,
    output logic [2:0] ROM_PAGE_PINS_O,
    output logic ROM_PAGE_PINS_OE_O
);
    // =====================================================
    // Register map
    localparam logic [3:0] REG_CFG = 4'h0;
    localparam logic [3:0] REG_PAGE = 4'h1;
    localparam logic [3:0] REG_STAT = 4'h2;

    hbsr_mode_e mode;
    hbsr_dec_s dec;
    hbsr_strap_s strap;
    logic [`HBSR_CFG_W-1:0] cfg_ff;
    logic [2:0] page_ff;
    logic [15:0] rdata_ff;
    logic live_ff;
    logic setup;
    logic zero_wait_select;
    logic io_strobe;
    logic mem_strobe;

    assign mode = hbsr_mode_e'(MODE_I);
    assign setup = !SETUP_N_I;
    assign zero_wait_select = mode == HBSR_UNBUFFERED_HOST_MODE && cfg_ff[`HBSR_ZWS_BIT];
    assign mem_strobe = !MEM_RD_N_I || !MEM_WR_N_I;
    // ISA DMA cycles put memory addresses beside io strobes
    assign io_strobe = (!IO_RD_N_I || !IO_WR_N_I) &&
                       !(mode != HBSR_MC && ADDR_EN_I);

    hbsr_strap_latch u_strap (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .sense_i(ROM_PAGE_PINS_I),
        .paging_i(ROM_PAGING_STRAP_I),
        .strap_o(strap)
    );

    hbsr_decode u_dec (
        .addr_i(ADDR_I),
        .is_mem_i(MEM_CYCLE_I),
        .high_mem_i(HIGH_MEM_I),
        .setup_i(setup),
        .dec_o(dec)
    );

    // =====================================================
    // Register port
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cfg_ff <= '0;
        end else if (REG_WR_I && REG_ADDR_I == REG_CFG) begin
            cfg_ff <= REG_WDATA_I[`HBSR_CFG_W-1:0];
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            page_ff <= `HBSR_PAGE_RST;
        end else if (REG_WR_I && REG_ADDR_I == REG_PAGE) begin
            page_ff <= REG_WDATA_I[2:0];
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rdata_ff <= 16'h0000;
        end else if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                REG_CFG: rdata_ff <= {{(16-`HBSR_CFG_W){1'b0}}, cfg_ff};
                REG_PAGE: rdata_ff <= {13'h0000, page_ff};
                REG_STAT: rdata_ff <= {12'h000, strap.paging, strap.sense};
                default: rdata_ff <= 16'h0000;
            endcase
        end else begin
            rdata_ff <= 16'h0000;
        end
    end

    assign REG_RDATA_O = rdata_ff;

    // =====================================================
    // Reset release marker for pin direction
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            live_ff <= 1'b0;
        end else begin
            live_ff <= 1'b1;
        end
    end

    // =====================================================
    // Width acknowledges and card select feedback
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            MEM_WIDTH_ACK_N_O <= 1'b1;
            MEM_WIDTH_ACK_OE_O <= 1'b0;
        end else begin
            unique case (mode)
                HBSR_UNBUFFERED_HOST_MODE: begin
                    MEM_WIDTH_ACK_N_O <= !dec.mem_hit;
                    MEM_WIDTH_ACK_OE_O <= 1'b1;
                end
                HBSR_MC: begin
                    MEM_WIDTH_ACK_N_O <= !(dec.mem_hit || dec.io_hit ||
                                           dec.rom_hit || dec.slot_io);
                    MEM_WIDTH_ACK_OE_O <= 1'b1;
                end
                default: begin
                    MEM_WIDTH_ACK_N_O <= 1'b1;
                    MEM_WIDTH_ACK_OE_O <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            IO_WIDTH_ACK_N_O <= 1'b1;
            IO_WIDTH_ACK_OE_O <= 1'b0;
        end else if (mode == HBSR_MC) begin
            IO_WIDTH_ACK_N_O <= !((dec.mem_hit || dec.io_hit) &&
                                  !dec.excl_hit && !PALETTE_HIT_I);
            IO_WIDTH_ACK_OE_O <= 1'b1;
        end else begin
            IO_WIDTH_ACK_N_O <= !(dec.io16_hit && !ADDR_EN_I);
            IO_WIDTH_ACK_OE_O <= 1'b1;
        end
    end

    // =====================================================
    // Interrupt pin and zero wait request
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            INT_PIN_O <= 1'b0;
            INT_PIN_OE_O <= 1'b0;
        end else if (zero_wait_select) begin
            // Interrupts are never shown in this mode
            INT_PIN_O <= !(PIXEL_PORT_HIT_I &&
                           ((!MEM_WR_N_I && !QUEUE_FULL_I) ||
                            (!MEM_RD_N_I && READ_READY_I)));
            INT_PIN_OE_O <= 1'b1;
        end else if (mode == HBSR_MC) begin
            INT_PIN_O <= 1'b0;
            INT_PIN_OE_O <= INT_ENABLE_I && INT_PENDING_I;
        end else begin
            INT_PIN_O <= INT_PENDING_I;
            INT_PIN_OE_O <= INT_ENABLE_I;
        end
    end

    // =====================================================
    // ROM select
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ROM_SELECT_N_O <= 1'b1;
            ROM_SELECT_OE_O <= 1'b0;
        end else if (mode == HBSR_MC) begin
            ROM_SELECT_N_O <= !((dec.rom_hit && mem_strobe) ||
                                (dec.slot_io && io_strobe));
            ROM_SELECT_OE_O <= 1'b1;
        end else begin
            ROM_SELECT_N_O <= !(dec.rom_hit && mem_strobe);
            ROM_SELECT_OE_O <= 1'b1;
        end
    end

    // =====================================================
    // ROM page pins
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ROM_PAGE_PINS_O <= `HBSR_PAGE_RST;
            ROM_PAGE_PINS_OE_O <= 1'b0;
        end else begin
            ROM_PAGE_PINS_O <= setup ? 3'h7 : page_ff;
            ROM_PAGE_PINS_OE_O <= live_ff && strap.paging;
        end
    end
endmodule

//--- dv/hbsr_monitor.sv
// Port checker for the host bus status and ROM paging block
`timescale 1ns/1ps
module hbsr_monitor import hbsr_pkg::*; (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic [1:0] MODE_I,
    input wire logic [23:0] ADDR_I,
    input wire logic MEM_CYCLE_I,
    input wire logic ADDR_EN_I,
    input wire logic MEM_RD_N_I,
    input wire logic MEM_WR_N_I,
    input wire logic SETUP_N_I,
    input wire logic PIXEL_PORT_HIT_I,
    input wire logic QUEUE_FULL_I,
    input wire logic INT_ENABLE_I,
    input wire logic INT_PENDING_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [3:0] REG_ADDR_I,
    input wire logic [15:0] REG_WDATA_I,
    input wire logic [15:0] REG_RDATA_O,
    input wire logic IO_WIDTH_ACK_N_O,
    input wire logic INT_PIN_O,
    input wire logic INT_PIN_OE_O,
    input wire logic ROM_SELECT_N_O,
    input wire logic [2:0] ROM_PAGE_PINS_O,
    input wire logic ROM_PAGE_PINS_OE_O
);
    // ==========
    // Helper state
    logic [1:0] age_ff;
    logic zws_ff;
    logic rdy, isa, mc, io16, isa_io16, isa_dma, mc_irq, zw, rom_rd;
    logic [2:0] wpage;
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            age_ff <= 2'h0;
        end else if (age_ff != 2'h3) begin
            age_ff <= age_ff + 2'h1;
        end
    end
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            zws_ff <= 1'h0;
        end else if (REG_WR_I && REG_ADDR_I == 4'h0) begin
            zws_ff <= REG_WDATA_I[8];
        end
    end
    // Strap capture and page direction settle before checks start
    assign rdy = (age_ff == 2'h3);
    assign isa = (MODE_I == HBSR_ISA);
    assign mc = (MODE_I == HBSR_MC);
    assign io16 = !MEM_CYCLE_I && (ADDR_I[9:0] == 10'h2E8);
    assign isa_io16 = isa && io16 && !ADDR_EN_I;
    assign isa_dma = isa && ADDR_EN_I;
    assign mc_irq = mc && INT_ENABLE_I && INT_PENDING_I;
    assign zw = (MODE_I == HBSR_UNBUFFERED_HOST_MODE) && zws_ff && PIXEL_PORT_HIT_I && !MEM_WR_N_I && !QUEUE_FULL_I;
    assign rom_rd = isa && MEM_CYCLE_I && (ADDR_I[23:13] == 11'h063) && !MEM_RD_N_I;
    assign wpage = REG_WDATA_I[2:0];
    // ==========
    // Properties
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    sequence s_page_wr;
        rdy && REG_WR_I && REG_ADDR_I == 4'h1 ##1 !REG_WR_I && SETUP_N_I;
    endsequence
    a_io_ack_isa: assert property (rdy && $past(isa_io16) |-> !IO_WIDTH_ACK_N_O)
        else $error("io width ack missing");
    a_dma_ignored: assert property (rdy && $past(isa_dma) |-> IO_WIDTH_ACK_N_O)
        else $error("io ack during dma");
    a_int_isa: assert property (rdy && $past(isa) |-> INT_PIN_OE_O == $past(INT_ENABLE_I)
        && (!INT_PIN_OE_O || INT_PIN_O == $past(INT_PENDING_I))) else $error("isa irq pin");
    a_int_mc: assert property (rdy && $past(mc) |-> !INT_PIN_O && INT_PIN_OE_O == $past(mc_irq))
        else $error("mc irq pin");
    a_zero_wait_req: assert property (rdy && $past(zw) |-> INT_PIN_OE_O && !INT_PIN_O)
        else $error("zero wait request missing");
    a_rom_sel_isa: assert property (rdy && $past(rom_rd) |-> !ROM_SELECT_N_O)
        else $error("rom select missing");
    a_page_setup: assert property (rdy && !$past(SETUP_N_I) |-> ROM_PAGE_PINS_O == 3'h7)
        else $error("setup page not high");
    a_page_dir: assert property (rdy |-> $stable(ROM_PAGE_PINS_OE_O))
        else $error("page pin direction changed");
    a_rdata_idle: assert property (rdy && !$past(REG_RD_I) |-> REG_RDATA_O == 16'h0000)
        else $error("read data outside slot");
    a_page_write: assert property (s_page_wr |=> ROM_PAGE_PINS_O == $past(wpage, 2))
        else $error("page pins not from field");
endmodule

bind hbsr_top hbsr_monitor u_hbsr_monitor (.*);

//--- dv/hbsr_host_model.sv
// Host side pin model: pull-ups, sense buffer held by reset
`timescale 1ns/1ps
module hbsr_host_model (
    input wire logic rstn_i,
    input wire logic [2:0] sense_i,
    input wire logic [2:0] page_i,
    input wire logic page_oe_i,
    input wire logic int_i,
    input wire logic int_oe_i,
    input wire logic rom_i,
    input wire logic rom_oe_i,
    output logic [2:0] page_o,
    output logic int_o,
    output logic rom_o
);
    always_comb begin
        if (!rstn_i) begin
            page_o = sense_i;
        end else if (page_oe_i) begin
            page_o = page_i;
        end else begin
            page_o = 3'h7;
        end
    end
    // Shared interrupt and ROM select lines rest high through pull-ups
    assign int_o = int_oe_i ? int_i : 1'h1;
    assign rom_o = rom_oe_i ? rom_i : 1'h1;
endmodule

//--- dv/testbench.sv
// Self-checking bench for the host bus status and ROM paging block
`timescale 1ns/1ps
module testbench import hbsr_pkg::*;;
    logic CLK_I = 1'h0, RSTN_I = 1'h0, MEM_CYCLE_I = 1'h0, HIGH_MEM_I = 1'h1, ADDR_EN_I = 1'h0;
    logic IO_RD_N_I = 1'h1, IO_WR_N_I = 1'h1, MEM_RD_N_I = 1'h1, MEM_WR_N_I = 1'h1;
    logic SETUP_N_I = 1'h1, PALETTE_HIT_I = 1'h0, PIXEL_PORT_HIT_I = 1'h0, QUEUE_FULL_I = 1'h0;
    logic READ_READY_I = 1'h0, INT_ENABLE_I = 1'h0, INT_PENDING_I = 1'h0;
    logic ROM_PAGING_STRAP_I = 1'h1, REG_WR_I = 1'h0, REG_RD_I = 1'h0;
    logic [1:0] MODE_I = 2'h0;
    logic [23:0] ADDR_I = 24'h000000;
    logic [3:0] REG_ADDR_I = 4'h0;
    logic [15:0] REG_WDATA_I = 16'h0000, REG_RDATA_O;
    logic [2:0] ROM_PAGE_PINS_I, ROM_PAGE_PINS_O, sense = 3'h5;
    logic MEM_WIDTH_ACK_N_O, MEM_WIDTH_ACK_OE_O, IO_WIDTH_ACK_N_O, IO_WIDTH_ACK_OE_O;
    logic INT_PIN_O, INT_PIN_OE_O, ROM_SELECT_N_O, ROM_SELECT_OE_O, ROM_PAGE_PINS_OE_O;
    logic int_line, rom_line;
    int fails = 0, tests_run = 0;
    hbsr_top u_hbsr_top (.*);
    hbsr_host_model u_hbsr_host_model (.rstn_i(RSTN_I), .sense_i(sense), .page_i(ROM_PAGE_PINS_O),
        .page_oe_i(ROM_PAGE_PINS_OE_O), .int_i(INT_PIN_O), .int_oe_i(INT_PIN_OE_O),
        .rom_i(ROM_SELECT_N_O), .rom_oe_i(ROM_SELECT_OE_O), .page_o(ROM_PAGE_PINS_I),
        .int_o(int_line), .rom_o(rom_line));
    always #20 CLK_I = ~CLK_I;
    // ==========
    // Shared tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic settle;
        @(posedge CLK_I);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLK_I);
        REG_WR_I <= 1'h1;
        REG_ADDR_I <= a;
        REG_WDATA_I <= d;
        @(posedge CLK_I);
        REG_WR_I <= 1'h0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge CLK_I);
        REG_RD_I <= 1'h1;
        REG_ADDR_I <= a;
        @(posedge CLK_I);
        REG_RD_I <= 1'h0;
        #1;
        chk(REG_RDATA_O, exp);
    endtask
    task automatic do_reset(input logic [2:0] s, input logic strap);
        @(posedge CLK_I);
        RSTN_I <= 1'h0;
        sense <= s;
        ROM_PAGING_STRAP_I <= strap;
        repeat (6) @(posedge CLK_I);
        chk(16'(rom_line), 16'h0001);
        RSTN_I <= 1'h1;
        repeat (4) @(posedge CLK_I);
    endtask
    task automatic finish_test;
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ==========
    // Scenarios
    task automatic t_straps;
        rd_chk(4'h2, 16'h000D);
        rd_chk(4'h1, 16'h0007);
        rd_chk(4'hF, 16'h0000);
        chk(16'({ROM_PAGE_PINS_OE_O, ROM_PAGE_PINS_I}), 16'h000F);
    endtask
    task automatic t_page;
        wr(4'h1, 16'h0003);
        settle();
        chk(16'(ROM_PAGE_PINS_I), 16'h0003);
        SETUP_N_I <= 1'h0;
        settle();
        chk(16'(ROM_PAGE_PINS_I), 16'h0007);
        SETUP_N_I <= 1'h1;
    endtask
    // Address, mode and strobes change one step per settled clock: io read low first, then memory write, then memory read
    task automatic t_decode;
        @(posedge CLK_I);
        ADDR_I <= 24'h0002E8;
        IO_RD_N_I <= 1'h0;
        settle();
        chk(16'({IO_WIDTH_ACK_N_O, MEM_WIDTH_ACK_OE_O}), 16'h0000);
        ADDR_EN_I <= 1'h1;
        settle();
        chk(16'(IO_WIDTH_ACK_N_O), 16'h0001);
        {MODE_I, ADDR_EN_I, SETUP_N_I, ADDR_I} <= {HBSR_MC, 2'h0, 24'h000100};
        settle();
        chk(16'(rom_line), 16'h0000);
        {SETUP_N_I, IO_RD_N_I, MEM_CYCLE_I, ADDR_I} <= {3'h7, 24'hA00000};
        settle();
        chk(16'({MEM_WIDTH_ACK_N_O, IO_WIDTH_ACK_N_O}), 16'h0000);
        {MODE_I, MEM_WR_N_I} <= {HBSR_UNBUFFERED_HOST_MODE, 1'h0};
        settle();
        chk(16'({MEM_WIDTH_ACK_OE_O, MEM_WIDTH_ACK_N_O}), 16'h0002);
        {MODE_I, MEM_WR_N_I, MEM_RD_N_I, ADDR_I} <= {HBSR_ISA, 2'h2, 24'h0C6000};
        settle();
        chk(16'(rom_line), 16'h0000);
        ADDR_I <= 24'h0C8000;
        settle();
        chk(16'(rom_line), 16'h0001);
        MEM_RD_N_I <= 1'h1;
    endtask
    task automatic t_irq;
        for (int i = 0; i < 8; i++) begin
            MODE_I <= i[2] ? HBSR_MC : HBSR_ISA;
            {INT_ENABLE_I, INT_PENDING_I} <= i[1:0];
            settle();
            chk(16'(int_line), i[2] ? 16'(!(i[1] && i[0])) : 16'(!i[1] || i[0]));
        end
    endtask
    task automatic t_zero_wait;
        wr(4'h0, 16'h0100);
        {MODE_I, MEM_WR_N_I, PIXEL_PORT_HIT_I} <= {HBSR_UNBUFFERED_HOST_MODE, 2'h1};
        settle();
        chk(16'(int_line), 16'h0000);
        QUEUE_FULL_I <= 1'h1;
        settle();
        chk(16'(int_line), 16'h0001);
        {MEM_WR_N_I, PIXEL_PORT_HIT_I, QUEUE_FULL_I} <= 3'h4;
        wr(4'h0, 16'h0000);
    endtask
    initial begin
        do_reset(3'h5, 1'h1);
        t_straps();
        t_page();
        t_decode();
        t_irq();
        t_zero_wait();
        do_reset(3'h2, 1'h0);
        chk(16'({ROM_PAGE_PINS_OE_O, ROM_PAGE_PINS_I}), 16'h0007);
        rd_chk(4'h2, 16'h0002);
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge CLK_I);
        fails++;
        finish_test();
    end
endmodule
